// ### core/lcp_pkg.sv
/*
  Shared definitions for the line interface control port: control scheme
  codes, strap encodings, strap pin positions on the shared bus and
  reset values.
  Assumes all pin inputs are already synchronous to the system clock.
*/
package lcp_pkg;

  // ---------------------------------------------------------------
  // Control scheme and bus state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LCP_MODE_HW,
    LCP_MODE_SERIAL,
    LCP_MODE_DS_MUX,
    LCP_MODE_SEP_MUX
  } lcp_mode_e;

  typedef enum logic [1:0] {
    LCP_BUS_IDLE,
    LCP_BUS_WAIT,
    LCP_BUS_DONE
  } lcp_bus_e;

  // ---------------------------------------------------------------
  // Strap encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] LCP_SEQ_NORMAL = 2'h0;
  localparam logic [1:0] LCP_SEQ_ONES = 2'h1;
  localparam logic [1:0] LCP_SEQ_PRBS = 2'h2;
  localparam logic [1:0] LCP_SEQ_TXPD = 2'h3;

  localparam logic [1:0] LCP_JA_OFF = 2'h0;
  localparam logic [1:0] LCP_JA_RX_BROAD = 2'h1;
  localparam logic [1:0] LCP_JA_RX_NARROW = 2'h2;
  localparam logic [1:0] LCP_JA_TX_NARROW = 2'h3;

  localparam logic [7:0] LCP_JA_DEPTH_SHORT = 8'h40;
  localparam logic [7:0] LCP_JA_DEPTH_LONG = 8'h80;

  localparam logic [4:0] LCP_GAIN_LOW_DB = 5'h00;
  localparam logic [4:0] LCP_GAIN_HIGH_DB = 5'h1A;

  // ---------------------------------------------------------------
  // Strap positions on the shared bus pins
  // ---------------------------------------------------------------
  localparam int LCP_SEQ_LSB = 0;
  localparam int LCP_RPD_BIT = 2;
  localparam int LCP_SHAPE_BIT = 4;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] LCP_BYTE_RST = 8'h00;
  localparam int LCP_ACCESS_CYCLES = 2;
  localparam int LCP_SER_WIDTH = 8;

endpackage

// ### core/lcp_ser_if.sv
/*
  Carrier between the control port top and its serial output shifter.
  Assumes one system clock shared by both ends.
*/
interface lcp_ser_if;
  logic en;
  logic sclk;
  logic edge_sel;
  logic load;
  logic [7:0] load_data;
  logic serial_data_out;

  modport ctrl (output en, output sclk, output edge_sel, output load,
    output load_data, input serial_data_out);
  modport shifter (input en, input sclk, input edge_sel, input load,
    input load_data, output serial_data_out);
endinterface

// ### core/lcp_serout.sv
/*
  Serial output shifter: launches one bit per active shift clock edge,
  most significant bit first.
  Assumes the shift clock is sampled as a plain synchronous input.
*/
module lcp_serout
  import lcp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  lcp_ser_if.shifter ser
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic sclk_q;
    logic [LCP_SER_WIDTH-1:0] shreg;
    logic serial_data_out;
  } lcp_ser_s;

  lcp_ser_s st;
  lcp_ser_s next_st;
  logic rise;
  logic fall;
  logic launch;

  always_comb begin
    next_st = st;
    rise = ser.sclk & ~st.sclk_q;
    fall = ~ser.sclk & st.sclk_q;
    launch = ser.en & (ser.edge_sel ? fall : rise);
    next_st.sclk_q = ser.sclk;
    if (ser.load) begin
      next_st.shreg = ser.load_data;
    end else if (launch) begin
      next_st.serial_data_out = st.shreg[LCP_SER_WIDTH-1];
      next_st.shreg = {st.shreg[LCP_SER_WIDTH-2:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ser.serial_data_out = st.serial_data_out;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_falling_launch: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (ser.en && ser.edge_sel && !ser.load && st.sclk_q && !ser.sclk)
      |=> (st.serial_data_out == $past(st.shreg[LCP_SER_WIDTH-1])))
    else $error("serial bit not launched on falling edge");

  chk_no_rise_launch: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    (ser.edge_sel && !st.sclk_q && ser.sclk) |=> $stable(st.serial_data_out))
    else $error("serial bit moved on rising edge");

endmodule

// ### core/lcp_top.sv
/*
  Control port front end of a single channel line interface: multiplexed
  address/data host bus in two strobe styles, strap decode in hardware
  control mode, serial output edge selection.
  Assumes every pin input is synchronous to sys_clk_i and that the
  internal register file answers a read within ACCESS_CYCLES cycles.
*/
// Functional notes
// - High edge select launches serial bits on falling edge
// - Separate-strobe mode drives bus only during read strobe
// - Data-strobe write: host drives, device captures under strobe
// - Data-strobe read: device drives bus during strobe
// - Shared pins carry address first, then data
// - Monitor strap: low 0 dB, high 26 dB
// - Shape strap selects pulse template and termination
// - Receiver powerdown strap: low normal, high down
// - Sequence strap: normal, ones, PRBS, transmitter down
// - Jitter strap picks position, bandwidth and FIFO depth
// - Scheme select: hardware, serial, data-strobe, separate-strobe
// - Address captured on falling address strobe
// - Ready low during access, high when complete
// - Acknowledge low when data valid or accepted
module lcp_top
  import lcp_pkg::*;
#(
  parameter int ACCESS_CYCLES = LCP_ACCESS_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] mode_sel_i,
  input wire logic chip_sel_n_i,
  input wire logic addr_strobe_n_i,
  input wire logic data_strobe_n_i,
  input wire logic rw_sel_i,
  input wire logic [7:0] ad_i,
  output logic [7:0] ad_o,
  output logic ad_oe_n_o,
  output logic rdy_ack_o,
  input wire logic [1:0] jitter_atten_config_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic sclk_i,
  input wire logic serial_out_edge_select_i,
  input wire logic ser_load_i,
  input wire logic [7:0] ser_load_data_i,
  output logic serial_data_out_o,
  output logic hw_mode_o,
  output logic [1:0] tx_sequence_select_o,
  output logic receiver_powerdown_o,
  output logic monitor_gain_select_o,
  output logic [4:0] monitor_gain_db_o,
  output logic tx_shape_select_o,
  output logic term_120_ohm_o,
  output logic [1:0] jitter_atten_config_o,
  output logic ja_enable_o,
  output logic ja_in_tx_path_o,
  output logic ja_narrow_bw_o,
  output logic [7:0] ja_fifo_depth_o
);

  if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 15) begin : g_bad_access
    $error("ACCESS_CYCLES must lie in 1..15");
  end

  localparam logic [3:0] ACC_LAST = 4'(ACCESS_CYCLES - 1);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    lcp_bus_e bus;
    logic [3:0] cnt;
    logic is_read;
    logic as_q;
    logic strobe_q;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rd_p;
    logic wr_p;
    logic hw;
    logic [1:0] seq;
    logic receiver_powerdown;
    logic monitor_gain_select;
    logic shape;
    logic [1:0] ja;
  } lcp_top_s;

  lcp_top_s st;
  lcp_top_s next_st;
  lcp_mode_e mode;
  logic mux;
  logic sep;
  logic strobe_low;
  logic start;
  logic rd_dir;

  always_comb begin
    mode = lcp_mode_e'(mode_sel_i);
    mux = (mode == LCP_MODE_DS_MUX) || (mode == LCP_MODE_SEP_MUX);
    sep = (mode == LCP_MODE_SEP_MUX);
    // Separate style: read strobe on the data strobe pin, write on the select pin
    strobe_low = mux & ~chip_sel_n_i &
      (sep ? (~data_strobe_n_i | ~rw_sel_i) : ~data_strobe_n_i);
    rd_dir = sep ? ~data_strobe_n_i : rw_sel_i;
    start = strobe_low & ~st.strobe_q;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rd_p = 1'b0;
    next_st.wr_p = 1'b0;
    next_st.strobe_q = strobe_low;
    next_st.as_q = addr_strobe_n_i;
    if (mux && st.as_q && !addr_strobe_n_i) begin
      next_st.addr = ad_i;
    end
    unique case (st.bus)
      LCP_BUS_IDLE: begin
        if (start) begin
          next_st.is_read = rd_dir;
          next_st.rd_p = rd_dir;
          next_st.wr_p = ~rd_dir;
          if (!rd_dir) begin
            next_st.wdata = ad_i;
          end
          next_st.cnt = ACC_LAST;
          next_st.bus = LCP_BUS_WAIT;
        end
      end
      LCP_BUS_WAIT: begin
        if (!strobe_low) begin
          next_st.bus = LCP_BUS_IDLE;
        end else if (st.cnt == 4'h0) begin
          if (st.is_read) begin
            next_st.rdata = reg_rdata_i;
          end
          next_st.bus = LCP_BUS_DONE;
        end else begin
          next_st.cnt = st.cnt - 4'h1;
        end
      end
      LCP_BUS_DONE: begin
        if (!strobe_low) begin
          next_st.bus = LCP_BUS_IDLE;
        end
      end
      default: begin
        next_st.bus = LCP_BUS_IDLE;
      end
    endcase
    // Straps sampled only in hardware mode, defaults otherwise
    next_st.hw = (mode == LCP_MODE_HW);
    if (mode == LCP_MODE_HW) begin
      next_st.seq = ad_i[LCP_SEQ_LSB +: 2];
      next_st.receiver_powerdown = ad_i[LCP_RPD_BIT];
      next_st.shape = ad_i[LCP_SHAPE_BIT];
      next_st.monitor_gain_select = data_strobe_n_i;
      next_st.ja = jitter_atten_config_i;
    end else begin
      next_st.seq = LCP_SEQ_NORMAL;
      next_st.receiver_powerdown = 1'b0;
      next_st.shape = 1'b0;
      next_st.monitor_gain_select = 1'b0;
      next_st.ja = LCP_JA_OFF;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Bus pins and register side
  // ---------------------------------------------------------------
  assign ad_o = st.rdata;
  // Drive only while a read strobe is held
  assign ad_oe_n_o = ~(strobe_low & rd_dir);
  always_comb begin
    if (sep) begin
      rdy_ack_o = ~(strobe_low & (st.bus != LCP_BUS_DONE));
    end else if (mode == LCP_MODE_DS_MUX) begin
      rdy_ack_o = ~(strobe_low & (st.bus == LCP_BUS_DONE));
    end else begin
      rdy_ack_o = 1'b1;
    end
  end
  assign reg_addr_o = st.addr;
  assign reg_wdata_o = st.wdata;
  assign reg_wr_o = st.wr_p;
  assign reg_rd_o = st.rd_p;

  // ---------------------------------------------------------------
  // Strap decode outputs
  // ---------------------------------------------------------------
  assign hw_mode_o = st.hw;
  assign tx_sequence_select_o = st.seq;
  assign receiver_powerdown_o = st.receiver_powerdown;
  assign monitor_gain_select_o = st.monitor_gain_select;
  assign monitor_gain_db_o = st.monitor_gain_select ? LCP_GAIN_HIGH_DB : LCP_GAIN_LOW_DB;
  assign tx_shape_select_o = st.shape;
  assign term_120_ohm_o = st.shape;
  assign jitter_atten_config_o = st.ja;
  assign ja_enable_o = (st.ja != LCP_JA_OFF);
  assign ja_in_tx_path_o = (st.ja == LCP_JA_TX_NARROW);
  assign ja_narrow_bw_o = (st.ja == LCP_JA_RX_NARROW) || (st.ja == LCP_JA_TX_NARROW);
  assign ja_fifo_depth_o = (st.ja == LCP_JA_OFF) ? LCP_BYTE_RST :
    (st.ja == LCP_JA_RX_BROAD) ? LCP_JA_DEPTH_SHORT : LCP_JA_DEPTH_LONG;

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  lcp_ser_if ser_if ();
  assign ser_if.en = (mode == LCP_MODE_SERIAL);
  assign ser_if.sclk = sclk_i;
  assign ser_if.edge_sel = serial_out_edge_select_i;
  assign ser_if.load = ser_load_i;
  assign ser_if.load_data = ser_load_data_i;
  assign serial_data_out_o = ser_if.serial_data_out;

  lcp_serout u_serout (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .ser(ser_if.shifter)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_write_start;
    (st.bus == LCP_BUS_IDLE) && start && !rd_dir;
  endsequence

  sequence s_read_start;
    (st.bus == LCP_BUS_IDLE) && start && rd_dir;
  endsequence

  chk_addr_capture: assert property (mux && st.as_q && !addr_strobe_n_i
    |=> reg_addr_o == $past(ad_i))
    else $error("address not captured on strobe fall");
  chk_write_data: assert property (s_write_start
    |=> reg_wr_o && !reg_rd_o && reg_wdata_o == $past(ad_i))
    else $error("write data not captured");
  chk_sep_drive: assert property (sep && !ad_oe_n_o
    |-> !data_strobe_n_i && !chip_sel_n_i)
    else $error("bus driven outside read strobe");
  chk_ds_drive: assert property ((mode == LCP_MODE_DS_MUX) && !chip_sel_n_i
    && !data_strobe_n_i && rw_sel_i |-> !ad_oe_n_o)
    else $error("bus not driven during data strobe read");
  chk_ready_low: assert property ((sep and s_read_start) |-> !rdy_ack_o ##1 reg_rd_o)
    else $error("ready not low at access start");
  chk_ready_done: assert property (sep && start |-> ##[1:16] (rdy_ack_o || !strobe_low))
    else $error("ready never returned high");
  chk_ack_read: assert property (((mode == LCP_MODE_DS_MUX) and s_read_start)
    |-> ##[1:16] ((!rdy_ack_o && !ad_oe_n_o && ad_o == $past(reg_rdata_i)) || !strobe_low))
    else $error("acknowledge never asserted");
  chk_ack_idle: assert property ((mode == LCP_MODE_DS_MUX) && start |-> rdy_ack_o)
    else $error("acknowledge low before access done");
  chk_seq_strap: assert property (mode == LCP_MODE_HW
    |=> tx_sequence_select_o == $past(ad_i[1:0]))
    else $error("sequence strap not followed");
  chk_rpd_strap: assert property (mode == LCP_MODE_HW
    |=> receiver_powerdown_o == $past(ad_i[LCP_RPD_BIT]))
    else $error("powerdown strap not followed");
  chk_gain_strap: assert property (mode == LCP_MODE_HW && data_strobe_n_i
    |=> monitor_gain_db_o == LCP_GAIN_HIGH_DB)
    else $error("monitor gain not high");
  chk_shape_strap: assert property (mode == LCP_MODE_HW
    |=> tx_shape_select_o == term_120_ohm_o && term_120_ohm_o == $past(ad_i[LCP_SHAPE_BIT]))
    else $error("shape strap not followed");
  chk_ja_strap: assert property (mode == LCP_MODE_HW
    && jitter_atten_config_i == LCP_JA_RX_BROAD
    |=> ja_enable_o && !ja_in_tx_path_o && !ja_narrow_bw_o
    && ja_fifo_depth_o == LCP_JA_DEPTH_SHORT)
    else $error("jitter strap decode wrong");
  chk_sw_quiet: assert property (mode != LCP_MODE_HW
    |=> !hw_mode_o && !receiver_powerdown_o && !ja_enable_o
    && tx_sequence_select_o == LCP_SEQ_NORMAL)
    else $error("strap acted outside hardware mode");

endmodule

// ### tb/lcp_host_model.sv
/*
  Host microcontroller model for the multiplexed address/data bus and
  the strap pins in hardware control mode.
  Assumes its caller enters the tasks on the falling clock edge.
*/
module lcp_host_model
  import lcp_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic [7:0] ad_o,
  input wire logic ad_oe_n_o,
  input wire logic rdy_ack_o,
  output logic chip_sel_n_o,
  output logic addr_strobe_n_o,
  output logic data_strobe_n_o,
  output logic rw_sel_o,
  output logic [7:0] ad_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] hd = 8'h00;
  logic drv = 1'b1;

  // Released bus shows device data while the device drives, else the inverse of the last host value
  assign ad_pin_o = drv ? hd : (!ad_oe_n_o ? ad_o : ~hd);

  initial begin
    chip_sel_n_o = 1'b1;
    addr_strobe_n_o = 1'b1;
    data_strobe_n_o = 1'b1;
    rw_sel_o = 1'b1;
  end

  task automatic straps(input logic [7:0] v, input logic monitor_gain_select);
    hd = v;
    drv = 1'b1;
    data_strobe_n_o = monitor_gain_select;
  endtask

  // One bus cycle: address phase, then data phase
  task automatic access(input logic sep, input logic wr, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic oe_in,
    output logic oe_out, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    chip_sel_n_o = 1'b0;
    hd = a;
    drv = 1'b1;
    @(negedge sys_clk_i);
    addr_strobe_n_o = 1'b0;
    @(negedge sys_clk_i);
    hd = d;
    drv = wr;
    rw_sel_o = !wr;
    data_strobe_n_o = sep & wr;
    while (n < 20 && !ok) begin
      @(negedge sys_clk_i);
      n++;
      ok = sep ? (rdy_ack_o === 1'b1) : (rdy_ack_o === 1'b0);
    end
    q = ad_pin_o;
    oe_in = ad_oe_n_o;
    @(negedge sys_clk_i);
    data_strobe_n_o = 1'b1;
    rw_sel_o = 1'b1;
    addr_strobe_n_o = 1'b1;
    chip_sel_n_o = 1'b1;
    drv = 1'b1;
    #1;
    oe_out = ad_oe_n_o;
  endtask
endmodule

// ### tb/tb_top.sv
/*
  Self-checking bench for the control port: straps, both multiplexed
  bus styles and the serial output edge.
  Assumes a host model on the bus and a small register file here.
*/
module tb_top;
  import lcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic sys_clk_i, resetn_i, chip_sel_n_i, addr_strobe_n_i, data_strobe_n_i;
  logic rw_sel_i, ad_oe_n_o, rdy_ack_o, reg_wr_o, reg_rd_o, sclk_i;
  logic serial_out_edge_select_i, ser_load_i, serial_data_out_o, hw_mode_o;
  logic receiver_powerdown_o, monitor_gain_select_o, tx_shape_select_o;
  logic term_120_ohm_o, ja_enable_o, ja_in_tx_path_o, ja_narrow_bw_o;
  logic [1:0] mode_sel_i, jitter_atten_config_i, tx_sequence_select_o;
  logic [1:0] jitter_atten_config_o;
  logic [4:0] monitor_gain_db_o;
  logic [7:0] ad_i, ad_o, reg_addr_o, reg_wdata_o, reg_rdata_i;
  logic [7:0] ser_load_data_i, ja_fifo_depth_o, v;
  logic [7:0] mem [256];
  logic [31:0] strap_vec;
  logic p;
  int error_cnt = 0;
  int checked = 0;

  lcp_top #(.ACCESS_CYCLES(3)) lcp_top_inst (.sys_clk_i, .resetn_i, .mode_sel_i,
    .chip_sel_n_i, .addr_strobe_n_i, .data_strobe_n_i, .rw_sel_i, .ad_i, .ad_o,
    .ad_oe_n_o, .rdy_ack_o, .jitter_atten_config_i, .reg_addr_o, .reg_wdata_o,
    .reg_wr_o, .reg_rd_o, .reg_rdata_i, .sclk_i, .serial_out_edge_select_i,
    .ser_load_i, .ser_load_data_i, .serial_data_out_o, .hw_mode_o,
    .tx_sequence_select_o, .receiver_powerdown_o, .monitor_gain_select_o,
    .monitor_gain_db_o, .tx_shape_select_o, .term_120_ohm_o,
    .jitter_atten_config_o, .ja_enable_o, .ja_in_tx_path_o, .ja_narrow_bw_o,
    .ja_fifo_depth_o);

  lcp_host_model lcp_host_model_inst (.sys_clk_i, .ad_o, .ad_oe_n_o, .rdy_ack_o,
    .chip_sel_n_o(chip_sel_n_i), .addr_strobe_n_o(addr_strobe_n_i),
    .data_strobe_n_o(data_strobe_n_i), .rw_sel_o(rw_sel_i), .ad_pin_o(ad_i));

  assign strap_vec = {7'h00, hw_mode_o, tx_sequence_select_o, receiver_powerdown_o,
    monitor_gain_select_o, monitor_gain_db_o, tx_shape_select_o, term_120_ohm_o,
    jitter_atten_config_o, ja_enable_o, ja_in_tx_path_o, ja_narrow_bw_o,
    ja_fifo_depth_o};
  assign reg_rdata_i = mem[reg_addr_o];

  always @(posedge sys_clk_i) begin
    if (reg_wr_o === 1'b1) begin
      mem[reg_addr_o] <= reg_wdata_o;
    end
  end

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic acc(input logic sep, input logic wr, input logic [7:0] a,
    input logic [7:0] d);
    logic [7:0] q;
    logic oi, oo, ok;
    lcp_host_model_inst.access(sep, wr, a, d, q, oi, oo, ok);
    cmp(ok, 1);
    cmp(reg_addr_o, a);
    if (wr) begin
      cmp({oi, reg_wdata_o}, {1'b1, d});
    end else begin
      cmp({oi, oo, q}, {2'b01, d});
    end
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and tests
  // ---------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  initial begin
    #(100 * 3000);
    error_cnt++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    resetn_i = 1'b0;
    mode_sel_i = 2'h0;
    jitter_atten_config_i = 2'h0;
    sclk_i = 1'b0;
    serial_out_edge_select_i = 1'b1;
    ser_load_i = 1'b0;
    ser_load_data_i = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    repeat (2) @(negedge sys_clk_i);
    cmp({serial_data_out_o, reg_wr_o, reg_rd_o, strap_vec[28:0]}, 0);
    resetn_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk_i);
      lcp_host_model_inst.straps({3'h0, i[1], 1'h0, i[0], i[1:0]}, i[0]);
      jitter_atten_config_i = i[1:0];
      repeat (3) @(negedge sys_clk_i);
      cmp(strap_vec, {7'h00, 1'b1, i[1:0], i[0], i[0],
        i[0] ? LCP_GAIN_HIGH_DB : LCP_GAIN_LOW_DB, i[1], i[1], i[1:0], i != 0,
        i == 3, i >= 2, (i == 0) ? 8'h00 : ((i == 1) ? 8'h40 : 8'h80)});
    end
    mode_sel_i = 2'h3;
    repeat (3) @(negedge sys_clk_i);
    cmp(strap_vec, 0);
    $display("test straps done");
    for (int m = 3; m >= 2; m--) begin
      mode_sel_i = 2'(m);
      @(negedge sys_clk_i);
      acc(m == 3, 1'b1, 8'h3C ^ 8'(m), 8'h96 ^ 8'(m));
      acc(m == 3, 1'b0, 8'h3C ^ 8'(m), 8'h96 ^ 8'(m));
      acc(m == 3, 1'b0, 8'hF0 + 8'(m), (8'hF0 + 8'(m)) ^ 8'h5A);
      $display("test bus mode %0d done", m);
    end
    mode_sel_i = 2'h1;
    // Falling edge active first, then rising edge active
    for (int e = 1; e >= 0; e--) begin
      serial_out_edge_select_i = e[0];
      sclk_i = ~e[0];
      @(negedge sys_clk_i);
      ser_load_i = 1'b1;
      ser_load_data_i = e[0] ? 8'hA5 : 8'h3C;
      @(negedge sys_clk_i);
      ser_load_i = 1'b0;
      for (int b = 0; b < 8; b++) begin
        p = serial_data_out_o;
        sclk_i = e[0];
        repeat (3) @(negedge sys_clk_i);
        cmp(serial_data_out_o, p);
        sclk_i = ~e[0];
        repeat (3) @(negedge sys_clk_i);
        v = {v[6:0], serial_data_out_o};
      end
      cmp(v, e[0] ? 8'hA5 : 8'h3C);
      $display("test serial edge %0d done", e);
    end
    wrap_up();
  end
endmodule
